//--- verilog/imdc_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the interrupt-mask and deferral-control register bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef IMDC_REGS_SVH
`define IMDC_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define IMDC_ADDR_W        8
`define IMDC_OFS_MASKCTL   8'h00
`define IMDC_OFS_CTRL      8'h04
`define IMDC_OFS_STATUS    8'h08

// ------------------------------------------------------------
// Mask and deferral-control word fields
// ------------------------------------------------------------
`define IMDC_MDW_W         16
`define IMDC_MDW_RST       16'h0000
`define IMDC_MDW_WMASK     16'h1F7F
`define IMDC_MASK_HI       12
`define IMDC_MASK_LO       8
`define IMDC_M_MISS        12
`define IMDC_M_MEM         11
`define IMDC_M_RX          10
`define IMDC_M_TX          9
`define IMDC_M_INIT        8
`define IMDC_UF_NOSTOP     6
`define IMDC_LOOKAHD       5
`define IMDC_NO2PART       4
`define IMDC_MODBO         3
`define IMDC_SWAP          2
`define IMDC_RES_HI        1

// ------------------------------------------------------------
// Event flag vector positions (same order as the masks)
// ------------------------------------------------------------
`define IMDC_EV_W          5
`define IMDC_EV_MISS       4
`define IMDC_EV_MEM        3
`define IMDC_EV_RX         2
`define IMDC_EV_TX         1
`define IMDC_EV_INIT       0

// ------------------------------------------------------------
// Control and status word fields
// ------------------------------------------------------------
`define IMDC_CTRL_GIE      0
`define IMDC_ST_EV_LO      0
`define IMDC_ST_EV_HI      4
`define IMDC_ST_SUMMARY    5
`define IMDC_ST_INTOUT     6
`define IMDC_ST_HOLD       7
`define IMDC_ST_POLL       8

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IMDC_CLK_MHZ       40
`define IMDC_POLL_NS       1000
`define IMDC_POLL_CYC      (`IMDC_POLL_NS * `IMDC_CLK_MHZ / 1000)

`endif

//--- verilog/imdc_pkg.sv
// Types for the interrupt-mask and deferral-control register bank.
// Assumes imdc_regs.svh supplies widths used by the state record.
`default_nettype none
`include "imdc_regs.svh"

package imdc_pkg;

    // Receive look-ahead ring scan states, one-hot
    typedef enum logic [4:0] {
        IMDC_SC_IDLE  = 5'h01,
        IMDC_SC_READ  = 5'h02,
        IMDC_SC_CLEAR = 5'h04,
        IMDC_SC_POLL  = 5'h08,
        IMDC_SC_HOLD  = 5'h10
    } imdc_scan_t;

    // Whole state of the block
    typedef struct packed {
        logic [`IMDC_MDW_W-1:0]  mdw;
        logic                    ienable;
        logic                    ack;
        logic [31:0]             rdata;
        imdc_scan_t              scan;
        logic [7:0]              pollCnt;
        logic                    advance;
        logic [31:0]             fifoOut;
        logic                    txOnClr;
        logic                    txRescan;
        logic                    rxEvent;
        logic                    summary;
        logic                    intOut;
    } imdc_state_t;

endpackage

`default_nettype wire

//--- verilog/imdc_mask_ctrl.sv
// Interrupt-mask and deferral-control register bank with Wishbone slave,
// summary interrupt gating, underflow handling, look-ahead receive ring
// scan and FIFO byte-lane swap.
// Assumes all inputs come from logic on clk; descriptor memory and the
// MAC answer the request/ack pairs below.
//
// Behaviour
// RQ1: Missed-frame mask bit 12 blocks missed-frame flag from summary.
// RQ2: Memory-error mask bit 11 blocks memory-error flag from summary.
// RQ3: Receive mask bit 10 blocks receive flag from summary.
// RQ4: Transmit mask bit 9 blocks transmit flag from summary.
// RQ5: Init-done mask bit 8 blocks init-done flag from summary.
// RQ6: Fields clear on hard or soft reset, always accessible, kept on stop.
// RQ7: Underflow with bit 6 clear turns transmitter off.
// RQ8: Underflow with bit 6 set rescans ring for next frame start.
// RQ9: Look-ahead raises receive event after first and last descriptors.
// RQ10: Look-ahead starts packets only at start-of-packet descriptors.
// RQ11: Scan past ownership, clearing own bit on device-owned non-start.
// RQ12: Host-owned start descriptor stops scan and is polled periodically.
// RQ13: Device-owned start descriptor stops scan, kept, awaits next frame.
// RQ14: Bit 4 selects single-part deferral instead of two-part.
// RQ15: Modified back-off enable selects modified back-off algorithm.
// RQ16: Big-endian maps lane 31:24 to byte 0; little-endian to byte 3.
// RQ17: Swap applies only to FIFO data, never other transfers.
// RQ18: Host should keep byte swap zero on little-endian buses.
// RQ19: Reserved bits 1-0 store and read back written value.
// RQ20: Reserved bits 15-13 and 7 read as zero.
// RQ21: Interrupt output active only with global enable and summary set.
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "imdc_regs.svh"

module imdc_mask_ctrl
    import imdc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        swReset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt gating
    input  wire logic [4:0]  eventFlags,
    output logic             summaryInterrupt,
    output logic             interruptOut,
    // MAC controls
    output logic             twoPartDeferralDisable,
    output logic             modifiedBackoffEnable,
    input  wire logic        txUnderflow,
    output logic             txOnClear,
    output logic             txRingRescan,
    // Receive look-ahead
    input  wire logic        rxFirstDone,
    input  wire logic        rxLastDone,
    input  wire logic        rxFrameStart,
    output logic             rxEventOut,
    output logic             descRdReq,
    input  wire logic        descRdAck,
    input  wire logic        descOwn,
    input  wire logic        descStart,
    output logic             descClrReq,
    input  wire logic        descClrAck,
    output logic             descAdvance,
    output logic             rxHold,
    // FIFO data path
    input  wire logic        xferIsFifo,
    input  wire logic [31:0] busData,
    output logic      [31:0] fifoData
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Merges write data into a word by byte enables
    function automatic logic [31:0] laneMerge(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Summary term: any flag not masked
    function automatic logic unmasked(
        input logic [`IMDC_EV_W-1:0]   flags,
        input logic [`IMDC_MDW_W-1:0]  csr
    );
        return |(flags & ~csr[`IMDC_MASK_HI:`IMDC_MASK_LO]);
    endfunction

    localparam logic [7:0] POLL_CYC = 8'(`IMDC_POLL_CYC);

    imdc_state_t s_q;
    imdc_state_t s_d;
    logic [31:0] swapped;
    logic [31:0] wordOld;
    logic [31:0] wordNew;

    // ------------------------------------------------------------
    // Byte-lane swap
    // ------------------------------------------------------------

    // RQ16: lane reversal
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gLane
            assign swapped[g*8 +: 8] = busData[(3-g)*8 +: 8];
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Register file, gating, scan machine and data path
    always_comb
    begin
        s_d         = s_q;
        s_d.advance = 1'b0;
        wordOld     = {16'h0000, s_q.mdw};
        wordNew     = laneMerge(wordOld, wb_dat_i, wb_sel_i);

        // Bus: ack one cycle after request, write at the ack edge
        s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
        if (wb_cyc_i && wb_stb_i && !s_q.ack)
        begin
            unique case (wb_adr_i)
                `IMDC_OFS_MASKCTL:
                    s_d.rdata = {16'h0000, s_q.mdw};
                `IMDC_OFS_CTRL:
                    s_d.rdata = {31'h0000_0000, s_q.ienable};
                `IMDC_OFS_STATUS:
                    s_d.rdata = {23'h00_0000,
                                 s_q.scan == IMDC_SC_POLL,
                                 s_q.scan == IMDC_SC_HOLD,
                                 s_q.intOut, s_q.summary, eventFlags};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (s_q.ack && wb_cyc_i && wb_stb_i && wb_we_i)
        begin
            // RQ19: reserved low bits kept; RQ20: others forced zero
            if (wb_adr_i == `IMDC_OFS_MASKCTL)
            begin
                s_d.mdw = wordNew[`IMDC_MDW_W-1:0] & `IMDC_MDW_WMASK;
            end
            if (wb_adr_i == `IMDC_OFS_CTRL && wb_sel_i[0])
            begin
                s_d.ienable = wb_dat_i[`IMDC_CTRL_GIE];
            end
        end

        // RQ1 RQ2 RQ3 RQ4 RQ5: masked flags kept out of summary
        s_d.summary = unmasked(eventFlags, s_q.mdw);
        // RQ21: output needs enable and summary
        s_d.intOut  = s_q.ienable && unmasked(eventFlags, s_q.mdw);

        // RQ7: stop transmitter on underflow
        s_d.txOnClr  = txUnderflow && !s_q.mdw[`IMDC_UF_NOSTOP];
        // RQ8: recover by rescanning for frame start
        s_d.txRescan = txUnderflow && s_q.mdw[`IMDC_UF_NOSTOP];

        // RQ9: extra event after first descriptor in look-ahead
        s_d.rxEvent = rxLastDone
                      || (rxFirstDone && s_q.mdw[`IMDC_LOOKAHD]);

        // RQ17: swap only FIFO data in big-endian mode
        if (xferIsFifo && s_q.mdw[`IMDC_SWAP])
        begin
            s_d.fifoOut = swapped;
        end
        else
        begin
            s_d.fifoOut = busData;
        end

        // RQ10: look-ahead ring scan for next start-of-packet
        unique case (s_q.scan)
            IMDC_SC_IDLE:
            begin
                if (rxLastDone && s_q.mdw[`IMDC_LOOKAHD])
                begin
                    s_d.advance = 1'b1;
                    s_d.scan    = IMDC_SC_READ;
                end
            end
            IMDC_SC_READ:
            begin
                if (descRdAck)
                begin
                    if (!descStart && descOwn)
                    begin
                        s_d.scan = IMDC_SC_CLEAR;
                    end
                    else if (!descStart)
                    begin
                        // RQ11: host-owned entry skipped untouched
                        s_d.advance = 1'b1;
                    end
                    else if (descOwn)
                    begin
                        // RQ13: keep descriptor, wait for frame
                        s_d.scan = IMDC_SC_HOLD;
                    end
                    else
                    begin
                        // RQ12: host-owned start, poll it
                        s_d.scan    = IMDC_SC_POLL;
                        s_d.pollCnt = POLL_CYC;
                    end
                end
            end
            IMDC_SC_CLEAR:
            begin
                // RQ11: own bit cleared, then move on
                if (descClrAck)
                begin
                    s_d.advance = 1'b1;
                    s_d.scan    = IMDC_SC_READ;
                end
            end
            IMDC_SC_POLL:
            begin
                if (s_q.pollCnt == 8'h00)
                begin
                    s_d.scan = IMDC_SC_READ;
                end
                else
                begin
                    s_d.pollCnt = s_q.pollCnt - 8'h01;
                end
            end
            IMDC_SC_HOLD:
            begin
                if (rxFrameStart)
                begin
                    s_d.scan = IMDC_SC_IDLE;
                end
            end
            default:
                s_d.scan = IMDC_SC_IDLE;
        endcase

        // RQ6: soft reset clears everything; stop has no input here
        if (swReset)
        begin
            s_d         = '0;
            s_d.mdw     = `IMDC_MDW_RST;
            s_d.scan    = IMDC_SC_IDLE;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // RQ6: hardware reset clears all fields
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_q      <= '0;
            s_q.mdw  <= `IMDC_MDW_RST;
            s_q.scan <= IMDC_SC_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Registered data and handshakes; requests decoded from scan state
    assign wb_dat_o               = s_q.rdata;
    assign wb_ack_o               = s_q.ack;
    assign summaryInterrupt       = s_q.summary;
    assign interruptOut           = s_q.intOut;
    // RQ14: deferral mode select
    assign twoPartDeferralDisable = s_q.mdw[`IMDC_NO2PART];
    // RQ15: back-off mode select
    assign modifiedBackoffEnable  = s_q.mdw[`IMDC_MODBO];
    assign txOnClear              = s_q.txOnClr;
    assign txRingRescan           = s_q.txRescan;
    assign rxEventOut             = s_q.rxEvent;
    assign descRdReq              = s_q.scan == IMDC_SC_READ;
    assign descClrReq             = s_q.scan == IMDC_SC_CLEAR;
    assign descAdvance            = s_q.advance;
    assign rxHold                 = s_q.scan == IMDC_SC_HOLD;
    assign fifoData               = s_q.fifoOut;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_miss_mask: assert property ( // RQ1
        eventFlags == (5'h01 << `IMDC_EV_MISS) && !swReset
        |=> summaryInterrupt == !$past(s_q.mdw[`IMDC_M_MISS]))
        else $error("missed-frame mask gating wrong");

    chk_mem_mask: assert property ( // RQ2
        eventFlags == (5'h01 << `IMDC_EV_MEM) && !swReset
        |=> summaryInterrupt == !$past(s_q.mdw[`IMDC_M_MEM]))
        else $error("memory-error mask gating wrong");

    chk_rx_mask: assert property ( // RQ3
        eventFlags == (5'h01 << `IMDC_EV_RX) && !swReset
        |=> summaryInterrupt == !$past(s_q.mdw[`IMDC_M_RX]))
        else $error("receive mask gating wrong");

    chk_tx_mask: assert property ( // RQ4
        eventFlags == (5'h01 << `IMDC_EV_TX) && !swReset
        |=> summaryInterrupt == !$past(s_q.mdw[`IMDC_M_TX]))
        else $error("transmit mask gating wrong");

    chk_init_mask: assert property ( // RQ5
        eventFlags == (5'h01 << `IMDC_EV_INIT) && !swReset
        |=> summaryInterrupt == !$past(s_q.mdw[`IMDC_M_INIT]))
        else $error("init-done mask gating wrong");

    chk_soft_reset: assert property ( // RQ6
        swReset |=> s_q.mdw == `IMDC_MDW_RST && !interruptOut)
        else $error("soft reset left fields set");

    chk_under_stop: assert property ( // RQ7
        txUnderflow && !s_q.mdw[`IMDC_UF_NOSTOP] && !swReset
        |=> txOnClear && !txRingRescan)
        else $error("underflow did not stop transmitter");

    chk_under_recover: assert property ( // RQ8
        txUnderflow && s_q.mdw[`IMDC_UF_NOSTOP] && !swReset
        |=> txRingRescan && !txOnClear)
        else $error("underflow did not trigger rescan");

    chk_lap_event: assert property ( // RQ9
        rxFirstDone && s_q.mdw[`IMDC_LOOKAHD] && !swReset |=> rxEventOut)
        else $error("look-ahead first event missing");

    chk_own_clear: assert property ( // RQ11
        descRdReq && descRdAck && descOwn && !descStart && !swReset
        |=> descClrReq && !descAdvance)
        else $error("device-owned entry not cleared");

    chk_poll_host: assert property ( // RQ12
        descRdReq && descRdAck && !descOwn && descStart && !swReset
        |=> !descRdReq [*8])
        else $error("host-owned start not held for polling");

    chk_hold_start: assert property ( // RQ13
        descRdReq && descRdAck && descOwn && descStart && !swReset
        |=> rxHold && !descAdvance)
        else $error("device-owned start not held");

    chk_swap_lane: assert property ( // RQ16
        xferIsFifo && s_q.mdw[`IMDC_SWAP] && !swReset
        |=> fifoData[7:0] == $past(busData[31:24]))
        else $error("big-endian lane mapping wrong");

    chk_no_swap: assert property ( // RQ17
        !xferIsFifo && !swReset |=> fifoData == $past(busData))
        else $error("non-FIFO transfer was swapped");

    chk_res_zero: assert property ( // RQ20
        s_q.mdw[15:13] == 3'b000 && s_q.mdw[7] == 1'b0)
        else $error("reserved bits not zero");

    chk_int_gate: assert property ( // RQ21
        interruptOut |-> summaryInterrupt && $past(s_q.ienable))
        else $error("interrupt output without enable");

endmodule

`default_nettype wire

//--- bench/imdc_desc_mem.sv
// Receive descriptor ring model facing the look-ahead scan of the block.
// Assumes scan requests arrive on clk as the block's hand-over describes.
`timescale 1ns/10ps
`default_nettype none

module imdc_desc_mem
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic descRdReq,
    input  wire logic descClrReq,
    input  wire logic descAdvance,
    output logic      descRdAck,
    output logic      descOwn,
    output logic      descStart,
    output logic      descClrAck,
    output int        readCnt,
    output int        clrCnt,
    output int        advCnt
);
    // ------------------------------------------------------------
    // Ring contents and answer timing
    // ------------------------------------------------------------
    logic [7:0] ringOwn;
    logic [7:0] ringStart;
    logic [2:0] idx;
    logic [1:0] waitCnt;

    // Entry 1 device-owned, entry 2 host-owned, entry 3 host-owned start;
    // the host hands entry 3 over once the scan has looked at it
    always_ff @(posedge clk)
    begin
        descRdAck <= 1'b0;
        descClrAck <= 1'b0;
        if (srst)
        begin
            ringOwn <= 8'h02;
            ringStart <= 8'h08;
            idx <= 3'h0;
            waitCnt <= 2'h1;
            readCnt <= 0;
            clrCnt <= 0;
            advCnt <= 0;
            descOwn <= 1'b0;
            descStart <= 1'b0;
        end
        else
        begin
            if (descAdvance)
            begin
                idx <= idx + 3'h1;
                advCnt <= advCnt + 1;
            end
            if (descRdReq && !descRdAck && waitCnt != 2'h0)
                waitCnt <= waitCnt - 2'h1;
            else if (descRdReq && !descRdAck)
            begin
                descRdAck <= 1'b1;
                descOwn <= ringOwn[idx];
                descStart <= ringStart[idx];
                readCnt <= readCnt + 1;
                waitCnt <= 2'($urandom_range(3, 1));
                if (idx == 3'h3)
                    ringOwn[3] <= 1'b1;
            end
            else
            begin
                // Stale descriptor fields are not left standing
                descOwn <= ~descOwn;
                descStart <= ~descStart;
            end
            if (descClrReq && !descClrAck)
            begin
                descClrAck <= 1'b1;
                ringOwn[idx] <= 1'b0;
                clrCnt <= clrCnt + 1;
            end
        end
    end
endmodule

`default_nettype wire

//--- bench/tb_interrupt_mask_deferral_ctrl.sv
// Self-checking bench for the interrupt-mask and deferral-control bank.
// Assumes imdc_regs.svh offsets and the descriptor ring model beside it.
`timescale 1ns/10ps
`default_nettype none
`include "imdc_regs.svh"

module tb_interrupt_mask_deferral_ctrl;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 0, srst = 1, swReset = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, busData = 0, fifoData, v;
    logic wb_ack_o, summaryInterrupt, interruptOut, tpdd, mbe;
    logic [4:0] eventFlags = 0, f, m;
    logic txUnderflow = 0, txOnClear, txRingRescan, e;
    logic rxFirstDone = 0, rxLastDone = 0, rxFrameStart = 0, rxEventOut;
    logic descRdReq, descRdAck, descOwn, descStart, descClrReq, descClrAck;
    logic descAdvance, rxHold, xferIsFifo = 0;
    int errTotal = 0, totalChecks = 0, readCnt, clrCnt, advCnt, i, n;

    // Free-running 40 MHz clock
    always #12.5 clk = ~clk;

    imdc_mask_ctrl i_dut (.clk(clk), .srst(srst), .swReset(swReset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .eventFlags(eventFlags),
        .summaryInterrupt(summaryInterrupt), .interruptOut(interruptOut),
        .twoPartDeferralDisable(tpdd), .modifiedBackoffEnable(mbe),
        .txUnderflow(txUnderflow), .txOnClear(txOnClear),
        .txRingRescan(txRingRescan), .rxFirstDone(rxFirstDone),
        .rxLastDone(rxLastDone), .rxFrameStart(rxFrameStart),
        .rxEventOut(rxEventOut), .descRdReq(descRdReq),
        .descRdAck(descRdAck), .descOwn(descOwn), .descStart(descStart),
        .descClrReq(descClrReq), .descClrAck(descClrAck),
        .descAdvance(descAdvance), .rxHold(rxHold),
        .xferIsFifo(xferIsFifo), .busData(busData), .fifoData(fifoData));

    imdc_desc_mem i_mem (.clk(clk), .srst(srst), .descRdReq(descRdReq),
        .descClrReq(descClrReq), .descAdvance(descAdvance),
        .descRdAck(descRdAck), .descOwn(descOwn), .descStart(descStart),
        .descClrAck(descClrAck), .readCnt(readCnt), .clrCnt(clrCnt),
        .advCnt(advCnt));

    // ------------------------------------------------------------
    // Expectations, checks and bus cycles
    // ------------------------------------------------------------
    function automatic logic [31:0] swapExp(logic [31:0] d, logic s);
        return s ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle: hold until ack seen, release at the ack edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int k;
        r = '0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20)
        begin
            errTotal++;
            print_verdict;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        wb(1'b0, a, 32'h0000_0000, r);
        chk(r, x);
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'h6cc9));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rdchk(`IMDC_OFS_MASKCTL, 32'h0000_0000);
        rdchk(`IMDC_OFS_CTRL, 32'h0000_0000);
        rdchk(8'h40, 32'h0000_0000);
        $display("test reset done");
        for (i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            wr(`IMDC_OFS_MASKCTL, v);
            rdchk(`IMDC_OFS_MASKCTL, v & 32'h0000_1F7F);
            chk(tpdd, v[4]);
            chk(mbe, v[3]);
        end
        $display("test readback done");
        for (i = 0; i < 16; i++)
        begin
            f = (i < 10) ? 5'h01 << (i % 5) : 5'($urandom);
            m = (i < 5) ? f : (i < 10) ? ~f : 5'($urandom);
            e = (i < 10) ? 1'b1 : 1'($urandom);
            wr(`IMDC_OFS_MASKCTL, {19'h0, m, 8'h00});
            wr(`IMDC_OFS_CTRL, {31'h0, e});
            @(posedge clk) eventFlags <= f;
            @(posedge clk);
            @(negedge clk);
            chk(summaryInterrupt, |(f & ~m));
            chk(interruptOut, e & |(f & ~m));
            rdchk(`IMDC_OFS_STATUS,
                  {25'h0, e & |(f & ~m), |(f & ~m), f});
            @(posedge clk) eventFlags <= 5'h00;
        end
        $display("test gating done");
        wr(`IMDC_OFS_MASKCTL, 32'h0000_1F7F);
        @(posedge clk) swReset <= 1'b1;
        @(posedge clk) swReset <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk(`IMDC_OFS_MASKCTL, 32'h0000_0000);
        rdchk(`IMDC_OFS_CTRL, 32'h0000_0000);
        $display("test soft reset done");
        for (i = 0; i < 2; i++)
        begin
            wr(`IMDC_OFS_MASKCTL, i << 6);
            @(posedge clk) txUnderflow <= 1'b1;
            @(posedge clk) txUnderflow <= 1'b0;
            @(negedge clk);
            chk(txOnClear, i == 0);
            chk(txRingRescan, i == 1);
        end
        $display("test underflow done");
        for (i = 0; i < 2; i++)
        begin
            wr(`IMDC_OFS_MASKCTL, i << 5);
            @(posedge clk) rxFirstDone <= 1'b1;
            @(posedge clk) rxFirstDone <= 1'b0;
            @(negedge clk);
            chk(rxEventOut, i == 1);
            @(posedge clk) rxLastDone <= 1'b1;
            @(posedge clk) rxLastDone <= 1'b0;
            @(negedge clk);
            chk(rxEventOut, 1'b1);
        end
        for (n = 0; n < 300 && rxHold !== 1'b1; n++)
            @(negedge clk);
        if (n >= 300)
        begin
            errTotal++;
            print_verdict;
        end
        chk(n >= 40, 1'b1);
        chk(advCnt, 3);
        chk(clrCnt, 1);
        repeat (10) @(negedge clk);
        chk(readCnt, 4);
        chk(descRdReq, 1'b0);
        rdchk(`IMDC_OFS_STATUS, 32'h0000_0080);
        @(posedge clk) rxFrameStart <= 1'b1;
        @(posedge clk) rxFrameStart <= 1'b0;
        repeat (2) @(negedge clk);
        chk(rxHold, 1'b0);
        $display("test ring scan done");
        for (i = 0; i < 8; i++)
        begin
            wr(`IMDC_OFS_MASKCTL, i[0] ? 32'h0000_0004 : 32'h0000_0000);
            @(posedge clk);
            xferIsFifo <= i[1];
            busData <= $urandom;
            @(posedge clk);
            @(negedge clk);
            chk(fifoData, swapExp(busData, i[0] & i[1]));
        end
        $display("test byte swap done");
        print_verdict;
    end
endmodule

`default_nettype wire
